// ---- rtl/cfc_fault_confinement.sv ----
`include "cfc_map.svh"
// Behaviour
// (RQ1) Three idle bits before data frames
// (RQ2) Flag bit error on driven/sampled mismatch
// (RQ3) No bit error for listed dominant exceptions
// (RQ4) Six equal stuffed bits give stuff error
// (RQ5) Wrong fixed bit gives form error
// (RQ6) Nonzero CRC remainder gives CRC error
// (RQ7) No dominant acknowledge gives ack error
// (RQ8) Eleven recessive bits before error active
// (RQ9) Error active sends dominant error flags
// (RQ10) Warning left when both counters below 96
// (RQ11) Warning entered when a counter reaches 96
// (RQ12) Passive above 127, active flag on entry
// (RQ13) Passive returns active when both below 128
// (RQ14) Bus off above 255, drivers disabled
// (RQ15) 128 idle runs recover, counters cleared
// (RQ16) Both tallies in one 16-bit word
// (RQ17) Receive tally stops once bit 7 set
// (RQ18) Add eight for flag bit errors
// (RQ19) Add eight on long dominant runs
// (RQ20) Other errors add one or eight
// (RQ21) Success decrements unless already zero
// (RQ22) Arbitration stuff bit error not counted
// (RQ23) Passive ack error without dominant uncounted
module cfc_fault_confinement #(
   parameter int TALLY_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic wake,
   input wire logic bit_strobe,
   input wire logic bus_rx,
   input wire logic tx_level,
   input wire logic transmitting,
   input wire logic in_stuffed_field,
   input wire logic in_arbitration,
   input wire logic in_ack_slot,
   input wire logic fixed_bit_check,
   input wire logic fixed_bit_value,
   input wire logic last_eof_bit,
   input wire logic crc_check,
   input wire logic crc_zero,
   input wire logic in_flag,
   input wire logic overload_flag,
   input wire logic flag_done,
   input wire logic frame_ok,
   input wire logic frame_start_req,
   output logic frame_start_ok,
   output logic flag_dominant,
   output logic driver_enable,
   output logic error_pulse,
   output logic bit_error,
   output logic stuff_error,
   output logic form_error,
   output logic crc_error,
   output logic ack_error,
   output logic [2:0] fault_state,
   output logic [15:0] fault_tally_register
);
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic rx_meta_reg, rx_reg, tx_level_q, exp_meta;
   // Bus pin crosses from outside; drive level is local but delayed alongside it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_meta_reg <= 1'b1;
         rx_reg <= 1'b1;
      end else begin
         rx_meta_reg <= bus_rx;
         rx_reg <= rx_meta_reg;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         exp_meta <= 1'b1;
         tx_level_q <= 1'b1;
      end else begin
         exp_meta <= tx_level;
         tx_level_q <= exp_meta;
      end
   end
   // Strobe is delayed by the same two cycles as the pin; frame context inputs are used undelayed
   logic [1:0] strobe_d;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strobe_d <= 2'h0;
      end else begin
         strobe_d <= {strobe_d[0], bit_strobe};
      end
   end
   logic sample;
   assign sample = strobe_d[1];

   // ************************************************************
   // State and counters
   // ************************************************************
   cfc_pkg::cfc_state_t state_reg, state_next;
   logic [TALLY_W-1:0] rx_tally_reg, tx_tally_reg;
   logic [3:0] rec_run_reg;
   logic [7:0] busoff_runs_reg;
   logic idle_run;
   logic tx_over_reg;
   logic [2:0] same_run_reg;
   logic [3:0] dom_run_reg;
   logic [3:0] dom_limit_reg;
   logic prev_bit_reg;
   logic after_flag_reg;
   logic flag_saw_dom_reg;
   logic ack_pending_reg;
   logic [1:0] ifs_reg;
   cfc_pkg::cfc_flag_t flag_kind_reg;

   // Decide whether a tally is at or over a limit
   function automatic logic at_or_over(input logic [TALLY_W-1:0] v, input logic [8:0] lim);
      at_or_over = ({1'b0, v} >= lim);
   endfunction

   // ************************************************************
   // Error detection
   // ************************************************************
   logic bit_err_c, stuff_err_c, form_err_c, crc_err_c, ack_err_c, dom_exempt;
   logic live;
   assign live = sample && state_reg != cfc_pkg::CFC_SYNC && state_reg != cfc_pkg::CFC_BUSOFF;
   // (RQ3) dominant exemptions
   assign dom_exempt = !rx_reg && tx_level_q &&
      ((in_flag && flag_kind_reg == cfc_pkg::CFC_FLAG_PASSIVE) || in_arbitration || in_ack_slot);
   always_comb begin
      // (RQ2) drive mismatch check
      bit_err_c = live && transmitting && (rx_reg != tx_level_q) && !dom_exempt;
      // (RQ4) six equal bits
      stuff_err_c = live && in_stuffed_field && prev_bit_reg == rx_reg &&
         same_run_reg == `CFC_STUFF_RUN - 3'h1;
      // (RQ5) fixed bit with exempt last EOF bit on reception
      form_err_c = live && fixed_bit_check && rx_reg != fixed_bit_value &&
         !(last_eof_bit && !transmitting && !rx_reg);
      // (RQ6) remainder check
      crc_err_c = live && crc_check && !crc_zero && !transmitting;
      // (RQ7) recessive acknowledge slot while sending
      ack_err_c = live && transmitting && in_ack_slot && rx_reg;
   end

   // Run of equal levels inside a stuffed field; bits before the field never count
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_bit_reg <= 1'b1;
         same_run_reg <= 3'h0;
      end else if (sample) begin
         prev_bit_reg <= rx_reg;
         if (!in_stuffed_field) begin
            same_run_reg <= 3'h0;
         end else if (same_run_reg == 3'h0 || prev_bit_reg != rx_reg) begin
            same_run_reg <= 3'h1;
         end else begin
            same_run_reg <= same_run_reg + 3'h1;
         end
      end
   end

   // ************************************************************
   // Flag tracking and dominant runs
   // ************************************************************
   logic any_err;
   assign any_err = bit_err_c | stuff_err_c | form_err_c | crc_err_c | ack_err_c;
   logic dom_hit;
   assign dom_hit = sample && flag_kind_reg != cfc_pkg::CFC_FLAG_NONE && after_flag_reg &&
      !rx_reg && dom_run_reg == dom_limit_reg - 4'h1;
   // (RQ19) count dominant bits from the flag start, acting only once the flag ends
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flag_kind_reg <= cfc_pkg::CFC_FLAG_NONE;
         dom_run_reg <= 4'h0;
         dom_limit_reg <= `CFC_ACT_DOM_RUN;
         after_flag_reg <= 1'b0;
         flag_saw_dom_reg <= 1'b0;
      end else if (any_err || (live && overload_flag && flag_kind_reg == cfc_pkg::CFC_FLAG_NONE)) begin
         flag_kind_reg <= overload_flag ? cfc_pkg::CFC_FLAG_OVERLOAD :
            (state_reg == cfc_pkg::CFC_PASSIVE ? cfc_pkg::CFC_FLAG_PASSIVE : cfc_pkg::CFC_FLAG_ACTIVE);
         dom_limit_reg <= state_reg == cfc_pkg::CFC_PASSIVE ? `CFC_PAS_DOM_RUN : `CFC_ACT_DOM_RUN;
         dom_run_reg <= 4'h0;
         after_flag_reg <= 1'b0;
         flag_saw_dom_reg <= 1'b0;
      end else if (sample && flag_kind_reg != cfc_pkg::CFC_FLAG_NONE) begin
         if (in_flag && !rx_reg) begin
            flag_saw_dom_reg <= 1'b1;
         end
         if (flag_done) begin
            after_flag_reg <= 1'b1;
         end
         if (rx_reg) begin
            flag_kind_reg <= after_flag_reg ? cfc_pkg::CFC_FLAG_NONE : flag_kind_reg;
            dom_run_reg <= 4'h0;
         end else if (dom_hit) begin
            dom_run_reg <= 4'h0;
            dom_limit_reg <= `CFC_EXTRA_DOM_RUN;
         end else begin
            dom_run_reg <= dom_run_reg + 4'h1;
         end
      end
   end

   // Ack errors on a passive node wait for the passive flag outcome
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_pending_reg <= 1'b0;
      end else if (ack_err_c && state_reg == cfc_pkg::CFC_PASSIVE) begin
         ack_pending_reg <= 1'b1;
      end else if (sample && flag_done) begin
         ack_pending_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Tally update
   // ************************************************************
   logic [8:0] rx_add, tx_add;
   logic rx_dec, tx_dec;
   logic first_after_flag;
   assign first_after_flag = sample && after_flag_reg && dom_run_reg == 4'h0 &&
      !rx_reg && !transmitting && flag_kind_reg != cfc_pkg::CFC_FLAG_OVERLOAD;
   always_comb begin
      rx_add = 9'h000;
      tx_add = 9'h000;
      rx_dec = 1'b0;
      tx_dec = 1'b0;
      // (RQ18) bit error during active flag, dominant after flag
      if (bit_err_c && in_flag && flag_kind_reg == cfc_pkg::CFC_FLAG_ACTIVE) begin
         if (transmitting) tx_add = `CFC_STEP_BIG;
         else rx_add = `CFC_STEP_BIG;
      end else if (first_after_flag) begin
         rx_add = `CFC_STEP_BIG;
      end else if (dom_hit) begin
         // (RQ19) long dominant run
         if (transmitting) tx_add = `CFC_STEP_BIG;
         else rx_add = `CFC_STEP_BIG;
      end else if (any_err && !transmitting) begin
         // (RQ20) receiver adds one
         rx_add = `CFC_STEP_ONE;
      end else if (any_err && !(stuff_err_c && in_arbitration && tx_level_q && !rx_reg)) begin
         // (RQ22) arbitration stuff exemption; (RQ23) passive ack deferred
         if (!(ack_err_c && state_reg == cfc_pkg::CFC_PASSIVE)) tx_add = `CFC_STEP_BIG;
      end else if (ack_pending_reg && sample && flag_done && flag_saw_dom_reg) begin
         // (RQ23) ack error counts only if flag saw dominant
         tx_add = `CFC_STEP_BIG;
      end
      // (RQ21) success decrement
      if (sample && frame_ok) begin
         if (transmitting) tx_dec = 1'b1;
         else rx_dec = 1'b1;
      end
   end

   logic [8:0] tx_sum;
   assign tx_sum = {1'b0, tx_tally_reg} + tx_add;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_tally_reg <= '0;
         tx_tally_reg <= '0;
      end else if (state_reg == cfc_pkg::CFC_BUSOFF && idle_run && busoff_runs_reg == `CFC_BUSOFF_RUNS - 8'h01) begin
         // (RQ15) clear on the last run, one cycle before the state leaves bus off
         rx_tally_reg <= '0;
         tx_tally_reg <= '0;
      end else begin
         // (RQ17) stop adding to receive tally once bit 7 set
         if (rx_add != 9'h000 && !rx_tally_reg[TALLY_W-1]) begin
            rx_tally_reg <= TALLY_W'(9'({1'b0, rx_tally_reg} + rx_add));
         end else if (rx_dec && rx_tally_reg != '0) begin
            rx_tally_reg <= rx_tally_reg - TALLY_W'(1);
         end
         if (tx_add != 9'h000) begin
            tx_tally_reg <= tx_sum[8] ? '1 : TALLY_W'(tx_sum);
         end else if (tx_dec && tx_tally_reg != '0) begin
            tx_tally_reg <= tx_tally_reg - TALLY_W'(1);
         end
      end
   end

   // ************************************************************
   // Recessive runs and state machine
   // ************************************************************
   assign idle_run = sample && rx_reg && rec_run_reg == `CFC_IDLE_RUN - 4'h1;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rec_run_reg <= 4'h0;
      end else if (!enable || wake || state_next != state_reg) begin
         rec_run_reg <= 4'h0;
      end else if (sample) begin
         rec_run_reg <= (!rx_reg || idle_run) ? 4'h0 : rec_run_reg + 4'h1;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busoff_runs_reg <= 8'h00;
      end else if (state_reg != cfc_pkg::CFC_BUSOFF) begin
         busoff_runs_reg <= 8'h00;
      end else if (idle_run) begin
         busoff_runs_reg <= busoff_runs_reg + 8'h01;
      end
   end

   logic tx_over;
   assign tx_over = tx_sum[8] && tx_add != 9'h000;
   // Bus off follows the saturated tally by one cycle, so state and tally outputs agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_over_reg <= 1'b0;
      end else begin
         tx_over_reg <= tx_over && state_reg != cfc_pkg::CFC_BUSOFF;
      end
   end
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cfc_pkg::CFC_SYNC: begin
            // (RQ8) eleven recessive bits
            if (enable && idle_run) state_next = cfc_pkg::CFC_ACTIVE;
         end
         cfc_pkg::CFC_ACTIVE, cfc_pkg::CFC_WARNING: begin
            if (at_or_over(rx_tally_reg, `CFC_PASSIVE_LIMIT) || at_or_over(tx_tally_reg, `CFC_PASSIVE_LIMIT))
               // (RQ12) over 127
               state_next = cfc_pkg::CFC_PASSIVE;
            else if (at_or_over(rx_tally_reg, `CFC_WARN_LIMIT) || at_or_over(tx_tally_reg, `CFC_WARN_LIMIT))
               // (RQ11) warning entry
               state_next = cfc_pkg::CFC_WARNING;
            else
               // (RQ10) back below 96
               state_next = cfc_pkg::CFC_ACTIVE;
         end
         cfc_pkg::CFC_PASSIVE: begin
            // (RQ13) both below 128
            if (!at_or_over(rx_tally_reg, `CFC_PASSIVE_LIMIT) && !at_or_over(tx_tally_reg, `CFC_PASSIVE_LIMIT)) begin
               // Warning is a sub-state of active, so land in it directly when still high
               if (at_or_over(rx_tally_reg, `CFC_WARN_LIMIT) || at_or_over(tx_tally_reg, `CFC_WARN_LIMIT))
                  state_next = cfc_pkg::CFC_WARNING;
               else
                  state_next = cfc_pkg::CFC_ACTIVE;
            end
         end
         cfc_pkg::CFC_BUSOFF: begin
            // (RQ15) 128 runs of eleven
            if (busoff_runs_reg == `CFC_BUSOFF_RUNS) state_next = cfc_pkg::CFC_ACTIVE;
         end
         default: state_next = cfc_pkg::CFC_SYNC;
      endcase
      // (RQ14) transmit tally over 255
      if (tx_over_reg && state_reg != cfc_pkg::CFC_SYNC) state_next = cfc_pkg::CFC_BUSOFF;
      if (!enable || wake) state_next = cfc_pkg::CFC_SYNC;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) state_reg <= cfc_pkg::CFC_SYNC;
      else state_reg <= state_next;
   end

   // ************************************************************
   // Interframe space and outputs
   // ************************************************************
   // (RQ1) count three recessive bits after a frame or flag
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ifs_reg <= 2'h0;
      end else if (any_err || (sample && (!rx_reg || frame_ok))) begin
         ifs_reg <= 2'h0;
      end else if (sample && ifs_reg != `CFC_IFS_BITS) begin
         ifs_reg <= ifs_reg + 2'h1;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_start_ok <= 1'b0;
         flag_dominant <= 1'b0;
         driver_enable <= 1'b0;
         fault_state <= 3'h0;
         fault_tally_register <= 16'h0000;
      end else begin
         frame_start_ok <= frame_start_req && ifs_reg == `CFC_IFS_BITS &&
            state_next != cfc_pkg::CFC_SYNC && state_next != cfc_pkg::CFC_BUSOFF;
         // (RQ9) (RQ12) dominant flags when active, and on the passive transition
         flag_dominant <= state_reg != cfc_pkg::CFC_PASSIVE || state_next == cfc_pkg::CFC_PASSIVE &&
            state_reg != cfc_pkg::CFC_PASSIVE;
         // (RQ14) drivers off in bus off and sync
         driver_enable <= state_next != cfc_pkg::CFC_BUSOFF && state_next != cfc_pkg::CFC_SYNC;
         fault_state <= state_next;
         // (RQ16) combined tally word
         fault_tally_register[`CFC_TX_MSB:`CFC_TX_LSB] <= 8'(tx_tally_reg);
         fault_tally_register[`CFC_RX_MSB:`CFC_RX_LSB] <= 8'(rx_tally_reg);
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         error_pulse <= 1'b0;
         bit_error <= 1'b0;
         stuff_error <= 1'b0;
         form_error <= 1'b0;
         crc_error <= 1'b0;
         ack_error <= 1'b0;
      end else begin
         error_pulse <= any_err;
         bit_error <= bit_err_c;
         stuff_error <= stuff_err_c;
         form_error <= form_err_c;
         crc_error <= crc_err_c;
         ack_error <= ack_err_c;
      end
   end
endmodule

// ---- rtl/cfc_map.svh ----
`ifndef CFC_MAP_SVH
`define CFC_MAP_SVH
// Counter thresholds and steps
`define CFC_WARN_LIMIT 9'h060
`define CFC_PASSIVE_LIMIT 9'h080
`define CFC_BUSOFF_LIMIT 9'h100
`define CFC_STEP_BIG 9'h008
`define CFC_STEP_ONE 9'h001
// Bit run lengths
`define CFC_IDLE_RUN 4'hb
`define CFC_STUFF_RUN 3'h6
`define CFC_ACT_DOM_RUN 4'he
`define CFC_PAS_DOM_RUN 4'h8
`define CFC_EXTRA_DOM_RUN 4'h8
`define CFC_BUSOFF_RUNS 8'h80
`define CFC_IFS_BITS 2'h3
// Field positions in the combined tally word
`define CFC_TX_MSB 15
`define CFC_TX_LSB 8
`define CFC_RX_MSB 7
`define CFC_RX_LSB 0
`endif

// ---- rtl/cfc_pkg.sv ----
package cfc_pkg;
   // Fault confinement states, Gray along sync, active, warning, passive, bus off
   typedef enum logic [2:0] {
      CFC_SYNC = 3'h0,
      CFC_ACTIVE = 3'h1,
      CFC_WARNING = 3'h3,
      CFC_PASSIVE = 3'h2,
      CFC_BUSOFF = 3'h6
   } cfc_state_t;
   // Flag kinds that follow an error or overload
   typedef enum logic [1:0] {
      CFC_FLAG_NONE = 2'h0,
      CFC_FLAG_ACTIVE = 2'h1,
      CFC_FLAG_PASSIVE = 2'h2,
      CFC_FLAG_OVERLOAD = 2'h3
   } cfc_flag_t;
endpackage

// ---- verification/cfc_fault_props.sv ----
// **********
// Port checker for the fault confinement block
// **********
module cfc_fault_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic bit_strobe,
   input wire logic bus_rx,
   input wire logic transmitting,
   input wire logic in_ack_slot,
   input wire logic fixed_bit_check,
   input wire logic fixed_bit_value,
   input wire logic crc_check,
   input wire logic crc_zero,
   input wire logic frame_start_ok,
   input wire logic driver_enable,
   input wire logic error_pulse,
   input wire logic form_error,
   input wire logic crc_error,
   input wire logic ack_error,
   input wire logic [2:0] fault_state,
   input wire logic [15:0] fault_tally_register
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Tally halves; error pulses land three cycles after the strobe, tally and state four
   wire [7:0] tx_t = fault_tally_register[15:8];
   wire [7:0] rx_t = fault_tally_register[7:0];
   a_crc_cause: assert property (crc_error |->
      $past(bit_strobe, 3) && $past(crc_check, 3) && !$past(crc_zero, 3))
      else $error("crc error without failing check");
   a_ack_cause: assert property (ack_error |->
      $past(transmitting, 3) && $past(in_ack_slot, 3) && $past(bus_rx, 3))
      else $error("ack error without recessive slot");
   a_form_cause: assert property (form_error |->
      $past(fixed_bit_check, 3) && ($past(bus_rx, 3) != $past(fixed_bit_value, 3)))
      else $error("form error on matching bit");
   a_pulse_once: assert property (error_pulse |=> !error_pulse)
      else $error("error pulse too long");
   a_warn_band: assert property (fault_state == cfc_pkg::CFC_WARNING |->
      (tx_t > 8'h5f || rx_t > 8'h5f) && !tx_t[7] && !rx_t[7])
      else $error("warning state out of band");
   a_active_band: assert property (fault_state == cfc_pkg::CFC_ACTIVE |-> tx_t < 8'h60 && rx_t < 8'h60)
      else $error("active state with high tally");
   a_passive_band: assert property (fault_state == cfc_pkg::CFC_PASSIVE |-> tx_t[7] || rx_t[7])
      else $error("passive state with low tallies");
   a_busoff_full: assert property (fault_state == cfc_pkg::CFC_BUSOFF |-> tx_t == 8'hff)
      else $error("bus off without full tally");
   a_busoff_quiet: assert property (fault_state == cfc_pkg::CFC_BUSOFF && $stable(fault_state) |-> !driver_enable)
      else $error("drivers on in bus off");
   a_start_gate: assert property (frame_start_ok && $stable(fault_state) |->
      fault_state != cfc_pkg::CFC_SYNC && fault_state != cfc_pkg::CFC_BUSOFF)
      else $error("frame start while off bus");
   a_rx_cap: assert property (rx_t[7] |=> rx_t <= $past(rx_t))
      else $error("receive tally grew past bit 7");
   a_tally_strobe: assert property ($changed(fault_tally_register) |-> $past(bit_strobe, 4))
      else $error("tally moved off a sample");
   c_passive: cover property (fault_state == cfc_pkg::CFC_PASSIVE);
   c_busoff: cover property (fault_state == cfc_pkg::CFC_BUSOFF);
   c_ack: cover property (ack_error);
endmodule
bind cfc_fault_confinement cfc_fault_props u_cfc_fault_props (.*);

// ---- verification/cfc_bus_nodes.sv ----
// **********
// Other nodes sharing the bus
// **********
module cfc_bus_nodes (
   input wire logic dev_level,
   input wire logic drv_en,
   input wire logic other_dom,
   output logic bus_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // Wired-AND: any dominant node wins; a device with drivers off reads as recessive
   assign bus_level = (dev_level | ~drv_en) & ~other_dom;
endmodule

// ---- verification/test_can_fault_confinement.sv ----
// **********
// Fault confinement bench
// **********
module test_can_fault_confinement;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'h0, rst = 1'h1, enable = 1'h1, wake = 1'h0, bit_strobe = 1'h0, tx_level = 1'h1;
   logic transmitting = 1'h0, in_stuffed_field = 1'h0, in_arbitration = 1'h0, in_ack_slot = 1'h0;
   logic fixed_bit_check = 1'h0, fixed_bit_value = 1'h1, last_eof_bit = 1'h0, crc_check = 1'h0;
   logic crc_zero = 1'h1, in_flag = 1'h0, overload_flag = 1'h0, flag_done = 1'h0, frame_ok = 1'h0;
   logic frame_start_req = 1'h1, other_dom = 1'h0, bus_rx, frame_start_ok, flag_dominant, driver_enable;
   logic error_pulse, bit_error, stuff_error, form_error, crc_error, ack_error;
   logic [2:0] fault_state;
   logic [15:0] fault_tally_register;
   logic [4:0] errs;
   logic [31:0] r;
   int err_total = 0, checks = 0, seed = 32'h5367, tx_m = 0, rx_m = 0, k;
   cfc_fault_confinement u_cfc_fault_confinement (.*);
   cfc_bus_nodes u_cfc_bus_nodes (.dev_level(tx_level), .drv_en(driver_enable), .other_dom(other_dom),
      .bus_level(bus_rx));
   // Verdict and end of run
   task automatic complete_run;
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Case equality, so an unknown never matches
   task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bit time of five cycles; one-cycle error pulses are caught while they stand
   task automatic bit1(input logic od);
      @(negedge core_clk);
      other_dom = od;
      bit_strobe = 1'h1;
      @(negedge core_clk);
      bit_strobe = 1'h0;
      repeat (2) @(negedge core_clk);
      errs = {bit_error, stuff_error, form_error, crc_error, ack_error};
      @(negedge core_clk);
   endtask
   task automatic bits(input int n, input logic od);
      repeat (n) bit1(od);
   endtask
   // Expected state from the modelled tallies
   function automatic logic [2:0] exp_state(input int t, input int rc);
      if (t > 255) return cfc_pkg::CFC_BUSOFF;
      if (t > 127 || rc > 127) return cfc_pkg::CFC_PASSIVE;
      if (t > 95 || rc > 95) return cfc_pkg::CFC_WARNING;
      return cfc_pkg::CFC_ACTIVE;
   endfunction
   task automatic chk;
      cmp(fault_tally_register, {tx_m[7:0], rx_m[7:0]});
      cmp(fault_state, exp_state(tx_m, rx_m));
   endtask
   // Unanswered ack slot; a passive sender also flags, seeing a dominant bit only if fd is set
   task automatic ack_err(input logic fd);
      in_ack_slot = 1'h1;
      bit1(1'h0);
      in_ack_slot = 1'h0;
      cmp(errs, 5'h01);
      if (exp_state(tx_m, rx_m) == cfc_pkg::CFC_PASSIVE) begin
         in_flag = 1'h1;
         bit1(fd);
         flag_done = 1'h1;
         bit1(1'h0);
         flag_done = 1'h0;
         in_flag = 1'h0;
         if (fd) tx_m += 8;
      end else begin
         tx_m += 8;
      end
   endtask
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      err_total++;
      complete_run;
   end
   // Main sequence
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 1'h0;
      cmp({fault_state, driver_enable, fault_tally_register}, 20'h0);
      bits(10, 1'h0);
      cmp(fault_state, cfc_pkg::CFC_SYNC);
      bit1(1'h0);
      cmp({fault_state, driver_enable, flag_dominant}, 5'h07);
      bit1(1'h1);
      bits(2, 1'h0);
      cmp(frame_start_ok, 1'h0);
      bit1(1'h0);
      cmp(frame_start_ok, 1'h1);
      crc_check = 1'h1;
      crc_zero = 1'h0;
      bit1(1'h0);
      cmp(errs, 5'h02);
      rx_m++;
      chk;
      crc_zero = 1'h1;
      bit1(1'h0);
      crc_check = 1'h0;
      cmp(errs, 5'h00);
      in_stuffed_field = 1'h1;
      bits(5, 1'h1);
      cmp(errs, 5'h00);
      bit1(1'h1);
      in_stuffed_field = 1'h0;
      cmp(errs, 5'h08);
      rx_m++;
      chk;
      last_eof_bit = 1'h1;
      fixed_bit_check = 1'h1;
      bit1(1'h1);
      last_eof_bit = 1'h0;
      cmp(errs, 5'h00);
      // Random fixed bits as receiver drive the tally until bit 7 is set
      for (k = 0; k < 400; k++) begin
         r = $random(seed);
         fixed_bit_value = r[0];
         bit1(r[1]);
         if (r[0] == r[1]) begin
            cmp(errs, 5'h04);
            if (rx_m < 128) rx_m++;
         end
         chk;
      end
      cmp(flag_dominant, 1'h0);
      fixed_bit_check = 1'h0;
      fixed_bit_value = 1'h1;
      frame_ok = 1'h1;
      for (k = 0; k < 130; k++) begin
         bit1(1'h0);
         if (rx_m > 0) rx_m--;
         chk;
      end
      frame_ok = 1'h0;
      @(negedge core_clk);
      wake = 1'h1;
      @(negedge core_clk);
      wake = 1'h0;
      bits(10, 1'h0);
      cmp(fault_state, cfc_pkg::CFC_SYNC);
      bit1(1'h0);
      cmp(fault_state, cfc_pkg::CFC_ACTIVE);
      // Random mix of failed and good transmissions up to error passive
      transmitting = 1'h1;
      for (k = 0; k < 300 && tx_m < 128; k++) begin
         r = $random(seed);
         if (r[1:0] != 2'h0) begin
            ack_err(1'h1);
         end else begin
            frame_ok = 1'h1;
            bit1(1'h0);
            frame_ok = 1'h0;
            if (tx_m > 0) tx_m--;
         end
         chk;
      end
      ack_err(1'h0);
      chk;
      for (k = 0; k < 40 && tx_m < 256; k++) begin
         ack_err(1'h1);
         if (tx_m < 256) chk;
      end
      transmitting = 1'h0;
      bits(1390, 1'h0);
      cmp({fault_state, fault_tally_register[15:8], driver_enable}, {cfc_pkg::CFC_BUSOFF, 8'hff, 1'h0});
      bits(30, 1'h0);
      cmp({fault_state, fault_tally_register}, {cfc_pkg::CFC_ACTIVE, 16'h0000});
      // Recessive stuff bit overwritten during arbitration
      transmitting = 1'h1;
      in_arbitration = 1'h1;
      in_stuffed_field = 1'h1;
      tx_level = 1'h0;
      bits(5, 1'h0);
      tx_level = 1'h1;
      bit1(1'h1);
      cmp(fault_tally_register[15:8], 8'h00);
      cmp(errs[4], 1'h0);
      in_stuffed_field = 1'h0;
      in_arbitration = 1'h0;
      bit1(1'h1);
      cmp(errs[4], 1'h1);
      in_ack_slot = 1'h1;
      bit1(1'h1);
      cmp(errs, 5'h00);
      complete_run;
   end
endmodule
